// File: verif/gpio7_pin_control_tb_top.sv
// Self-checking bench for the pin 7 control block
module gpio7_pin_control_tb_top
    import pin7_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DL = 8;
    localparam int DN = 2;
    logic sys_clk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic write_in = 1'h0;
    logic read_in = 1'h0;
    logic drv_en = 1'h1;
    logic drv_val = 1'h0;
    logic rd_seen = 1'h0;
    logic [15:0] addr_in = 16'h0000;
    logic [15:0] wdata_in = 16'h0000;
    logic [15:0] src = 16'h0000;
    logic [15:0] rdata_out;
    logic [11:0] fo;
    logic irq_out, pin_in, pin_out, pin_oe_out, pull_up_out, pull_down_out, supply_select_out;
    logic [15:0] exp_q[$];
    logic [31:0] rnd = 32'hb156_9510;
    int n_errors = 0;
    int total_checks = 0;
    int fidx[16] = '{0, 0, 1, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 10, 11};
    always #2.5 sys_clk_in = !sys_clk_in;
    pin7_control #(.DEB_LONG(DL), .DEB_NORMAL(DN)) pin7_control_i (.sys_clk_in, .resetn_in,
        .addr_in, .wdata_in, .write_in, .read_in, .rdata_out, .irq_out, .pin_in, .pin_out,
        .pin_oe_out, .pull_up_out, .pull_down_out, .supply_select_out,
        .osc_32k_in(src[1]), .on_state_in(src[2]), .sleep_state_in(src[3]),
        .state_change_in(src[4]), .vsa_done_in(src[8]), .vsb_done_in(src[9]),
        .ext_enable1_in(src[10]), .ext_enable2_in(src[11]), .system_supply_good_in(src[12]),
        .converter_power_good_in(src[13]), .power_clk_2m_in(src[14]), .aux_reset_in(src[15]),
        .level_out(fo[0]), .onoff_req_out(fo[1]), .sleepwake_req_out(fo[2]),
        .sleep_req_out(fo[3]), .poweron_req_out(fo[4]), .wdog_reset_out(fo[5]),
        .voltage_scale_select_a_out(fo[6]), .voltage_scale_select_b_out(fo[7]),
        .hw_enable1_out(fo[8]), .hw_enable2_out(fo[9]), .hw_control1_out(fo[10]),
        .hw_control2_out(fo[11]));
    pin7_board pin7_board_i (.sys_clk_in, .pad_val_in(pin_out), .pad_oe_in(pin_oe_out),
        .pull_up_in(pull_up_out), .pull_down_in(pull_down_out), .drive_en_in(drv_en),
        .drive_val_in(drv_val), .level_out(pin_in));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [15:0] cfg(input logic d, input logic [1:0] p, input logic m,
        input logic pol, input logic od, input logic en, input logic [3:0] fn);
        return {d, p, m, 1'h0, pol, od, 1'h0, en, 3'h0, fn};
    endfunction : cfg
    task automatic compare(input string what, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : compare
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : tick
    // Strobe drops on the next edge, so back-to-back calls leave one idle cycle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'h1;
        @(posedge sys_clk_in);
        write_in <= 1'h0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge sys_clk_in);
        addr_in <= a;
        read_in <= 1'h1;
        exp_q.push_back(e);
        @(posedge sys_clk_in);
        read_in <= 1'h0;
    endtask : rd
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    always @(posedge sys_clk_in) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) compare("read queue", 16'h0000, 16'hffff);
            else compare("read data", exp_q.pop_front(), rdata_out);
        end
        rd_seen <= read_in;
    end
    initial begin
        tick(20000);
        n_errors++;
        close_out();
    end
    initial begin
        int i, k;
        logic [15:0] v;
        logic seen;
        tick(5);
        resetn_in <= 1'h1;
        rd(CTRL_OFFSET, CTRL_RESET);
        rd(16'h4000, 16'h0000);
        for (i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr(CTRL_OFFSET, rnd[15:0]);
            rd(CTRL_OFFSET, rnd[15:0] & CTRL_WRITE_MASK);
            compare("supply", 16'(rnd[SUPPLY_BIT]), 16'(supply_select_out));
        end
        for (i = 0; i < 4; i++) begin
            wr(CTRL_OFFSET, cfg(1'h1, 2'(i), 1'h0, 1'h1, 1'h0, 1'h1, FN_IN_NORMAL));
            tick(3);
            compare("pulls", 16'({i == 2, i == 1}), 16'({pull_up_out, pull_down_out}));
        end
        drv_en <= 1'h0;
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 16; i++) begin
                rnd = lfsr(rnd);
                src <= rnd[15:0];
                wr(OUT_LEVEL_OFFSET, {15'h0000, rnd[0]});
                wr(CTRL_OFFSET, cfg(1'h0, PULL_NONE, 1'h0, k[0], 1'h0, 1'h1, 4'(i)));
                tick(3);
                v = (i inside {[5:7]}) ? 16'h0000 : 16'(rnd[i]);
                compare("drive", {14'h0000, 1'h1, v[0] ^ !k[0]}, 16'({pin_oe_out, pin_out}));
                rd(OUT_LEVEL_OFFSET, {15'h0000, rnd[0]});
            end
        end
        for (i = 0; i < 3; i++) begin
            wr(OUT_LEVEL_OFFSET, 16'(i[0]));
            wr(CTRL_OFFSET, cfg(1'h0, PULL_UP, 1'h0, 1'h1, 1'h1, i < 2, FN_OUT_LEVEL));
            tick(3);
            v = 16'({pull_up_out, pin_oe_out, pin_out & pin_oe_out});
            compare("open drain", 16'({i < 2, i == 0, 1'h0}), v);
        end
        drv_en <= 1'h1;
        drv_val <= 1'h1;
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 16; i++) begin
                wr(CTRL_OFFSET, cfg(1'h1, PULL_NONE, 1'h0, k[0], 1'h0, 1'h1, 4'(i)));
                tick(DL + 8);
                compare("route", 16'(k[0]) << fidx[i], 16'(fo));
                rd(PIN_STATE_OFFSET, {14'h0000, k[0], 1'h1});
            end
        end
        // A pulse between the two filter lengths must pass only the normal one
        for (i = 0; i < 2; i++) begin
            wr(CTRL_OFFSET, cfg(1'h1, PULL_NONE, 1'h0, 1'h1, 1'h0, 1'h1, 4'(i)));
            drv_val <= 1'h0;
            tick(DL + 8);
            drv_val <= 1'h1;
            tick(DL - 2);
            drv_val <= 1'h0;
            seen = 1'h0;
            repeat (DL + 8) begin
                @(posedge sys_clk_in);
                seen = seen | fo[0];
            end
            compare("short pulse", 16'(i), 16'(seen));
        end
        wr(IRQ_MASK_OFFSET, 16'h0001);
        rd(IRQ_MASK_OFFSET, 16'h0001);
        for (i = 0; i < 4; i++) begin
            wr(CTRL_OFFSET, cfg(1'h1, PULL_NONE, i[1], i[0], 1'h0, 1'h1, FN_IN_NORMAL));
            wr(IRQ_STATUS_OFFSET, 16'h0001);
            drv_val <= 1'h1;
            tick(DN + 10);
            rd(IRQ_STATUS_OFFSET, 16'(i[1] | i[0]));
            compare("irq", 16'(i[1] | i[0]), 16'(irq_out));
            wr(IRQ_STATUS_OFFSET, 16'h0001);
            drv_val <= 1'h0;
            tick(DN + 10);
            rd(IRQ_STATUS_OFFSET, 16'(i[1] | !i[0]));
        end
        wr(IRQ_MASK_OFFSET, 16'h0000);
        tick(3);
        compare("irq masked", 16'h0000, 16'(irq_out));
        close_out();
    end
endmodule : gpio7_pin_control_tb_top

// File: verif/pin7_board.sv
// Board-side model of the pad: other driver, pulls and a floating wire
module pin7_board (
    input wire logic sys_clk_in,
    input wire logic pad_val_in,
    input wire logic pad_oe_in,
    input wire logic pull_up_in,
    input wire logic pull_down_in,
    input wire logic drive_en_in,
    input wire logic drive_val_in,
    output logic level_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic float_reg = 1'h0;
    // A pad nobody holds is unknown, so it wanders rather than keeping a value
    always @(posedge sys_clk_in) float_reg <= !level_out;
    always_comb begin
        if (pad_oe_in) level_out = pad_val_in;
        else if (drive_en_in) level_out = drive_val_in;
        else if (pull_up_in) level_out = 1'h1;
        else if (pull_down_in) level_out = 1'h0;
        else level_out = float_reg;
    end
endmodule : pin7_board

// File: verif/pin7_control_sva.sv
// Port checks for the pin 7 control block
module pin7_checker
    import pin7_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic [15:0] rdata_out,
    input wire logic irq_out,
    input wire logic pin_out,
    input wire logic pin_oe_out,
    input wire logic pull_up_out,
    input wire logic pull_down_out,
    input wire logic supply_select_out,
    input wire logic system_supply_good_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] c_reg;
    logic lv_reg, mk_reg, want, drv;
    assign want = lv_reg ^ !c_reg[POL_BIT];
    assign drv = !c_reg[DIR_BIT] && c_reg[ENABLE_BIT];
    // Shadow of software writes, so outputs can be judged against them
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            c_reg <= CTRL_RESET;
            lv_reg <= 1'h0;
            mk_reg <= 1'h0;
        end else if (write_in) begin
            if (addr_in == CTRL_OFFSET) c_reg <= wdata_in & CTRL_WRITE_MASK;
            if (addr_in == OUT_LEVEL_OFFSET) lv_reg <= wdata_in[0];
            if (addr_in == IRQ_MASK_OFFSET) mk_reg <= wdata_in[0];
        end
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_steady;
        $stable(c_reg) && $stable(lv_reg);
    endsequence
    sequence s_sw_level;
        s_steady ##0 (drv && c_reg[FN_HI:FN_LO] == FN_OUT_LEVEL);
    endsequence
    chk_ctrl_readback: assert property (read_in && addr_in == CTRL_OFFSET |=>
        rdata_out == $past(c_reg)) else $error("control read data wrong");
    chk_pull_select: assert property ($stable(c_reg) |-> pull_up_out ==
        (c_reg[ENABLE_BIT] && c_reg[PULL_HI:PULL_LO] == PULL_UP) && pull_down_out ==
        (c_reg[ENABLE_BIT] && c_reg[PULL_HI:PULL_LO] == PULL_DOWN)) else $error("pull wrong");
    chk_supply_follow: assert property ($stable(c_reg) |->
        supply_select_out == c_reg[SUPPLY_BIT]) else $error("supply select wrong");
    chk_tristate_off: assert property ($stable(c_reg) && !drv |-> !pin_oe_out)
        else $error("pin driven while released");
    chk_push_level: assert property (s_sw_level ##0 !c_reg[OD_BIT] |->
        pin_oe_out && pin_out == want) else $error("push-pull level wrong");
    chk_drain_low: assert property (s_sw_level ##0 c_reg[OD_BIT] |->
        !pin_out && pin_oe_out == !want) else $error("open drain drive wrong");
    chk_supply_good: assert property (s_steady ##0 (drv && !c_reg[OD_BIT] &&
        c_reg[FN_HI:FN_LO] == FN_OUT_SYSTEM_SUPPLY_GOOD) |-> pin_out ==
        ($past(system_supply_good_in) ^ !c_reg[POL_BIT])) else $error("supply good wrong");
    chk_irq_masked: assert property (!mk_reg |-> !irq_out)
        else $error("interrupt while masked");
endmodule : pin7_checker
bind pin7_control pin7_checker pin7_checker_i (.sys_clk_in, .resetn_in, .addr_in,
    .wdata_in, .write_in, .read_in, .rdata_out, .irq_out, .pin_out, .pin_oe_out,
    .pull_up_out, .pull_down_out, .supply_select_out, .system_supply_good_in);

// File: verilog/pin7_control.sv
// Control register, pin driver and function routing for general-purpose pin 7
// Notes on behaviour
// R01 - Bit 15 direction, 1 input, reset input
// R02 - Bits 14:13 pull: none, down, up
// R03 - Mode 0: single edge chosen by polarity
// R04 - Mode 1: interrupt on both edges
// R05 - Bit 11 selects interface or always-on supply
// R06 - Polarity 0 inverts pin both ways
// R07 - Polarity 1 non-inverted, reset value
// R08 - Bit 9 open-drain drives low only
// R09 - Enable 0 tri-states pin, reset 0
// R10 - Input codes 0/1: long/normal filtered level
// R11 - Codes 2,3,4: on/off, sleep/wake requests
// R12 - Codes 5,6,7: sleep, power-on, watchdog
// R13 - Codes 8-11: voltage scale, hardware enables
// R14 - Codes 12-15: hardware controls, long variants
// R15 - Output 0-3: level, oscillator, ON, SLEEP
// R16 - Output 4 state change; 5-7 reserved
// R17 - Output 8-11: scale done, external enables
// R18 - Output 12/13: supply good, power good
// R19 - Output 14/15: power clock, auxiliary reset
//
// The plain strobed port was decided locally.
module pin7_control
    import pin7_pkg::*;
#(
    parameter int DEB_LONG = DEB_LONG_CYCLES,
    parameter int DEB_NORMAL = DEB_NORMAL_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [15:0] rdata_out,
    output logic irq_out,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    output logic pull_up_out,
    output logic pull_down_out,
    output logic supply_select_out,
    input wire logic osc_32k_in,
    input wire logic on_state_in,
    input wire logic sleep_state_in,
    input wire logic state_change_in,
    input wire logic vsa_done_in,
    input wire logic vsb_done_in,
    input wire logic ext_enable1_in,
    input wire logic ext_enable2_in,
    input wire logic system_supply_good_in,
    input wire logic converter_power_good_in,
    input wire logic power_clk_2m_in,
    input wire logic aux_reset_in,
    output logic level_out,
    output logic onoff_req_out,
    output logic sleepwake_req_out,
    output logic sleep_req_out,
    output logic poweron_req_out,
    output logic wdog_reset_out,
    output logic voltage_scale_select_a_out,
    output logic voltage_scale_select_b_out,
    output logic hw_enable1_out,
    output logic hw_enable2_out,
    output logic hw_control1_out,
    output logic hw_control2_out
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int CW = $clog2(DEB_LONG + 1);

    logic [15:0] ctrl_reg;
    logic out_level_reg;
    logic [IRQ_WIDTH-1:0] irq_status_reg;
    logic [IRQ_WIDTH-1:0] irq_mask_reg;
    logic [2:0] sync_reg;
    logic stable_reg;
    logic [CW-1:0] deb_cnt_reg;
    logic deb_reg;
    logic deb_prev_reg;
    logic [15:0] rdata_next;
    logic pin_dir_in;
    logic [1:0] pull_sel;
    logic [3:0] fn;
    logic long_filter;
    logic [CW-1:0] deb_limit;
    logic logic_level;
    logic edge_event;
    logic src_level;
    logic drive_level;
    logic deb_rise;
    logic deb_fall;
    logic fn_active;
    logic sel_level;
    logic sel_onoff;
    logic sel_sleepwake;
    logic sel_sleep;
    logic sel_poweron;
    logic sel_wdog;
    logic sel_vsa;
    logic sel_vsb;
    logic sel_hwen1;
    logic sel_hwen2;
    logic sel_hwctl1;
    logic sel_hwctl2;

    assign pin_dir_in = ctrl_reg[DIR_BIT];
    assign pull_sel = ctrl_reg[PULL_HI:PULL_LO];
    assign fn = ctrl_reg[FN_HI:FN_LO];

    // Register writes
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ctrl_reg <= CTRL_RESET; // R01 R02 R04 R05 R07 R08 R09 R10
            out_level_reg <= 1'b0;
            irq_mask_reg <= '0;
        end else if (write_in) begin
            if (addr_in == CTRL_OFFSET) begin
                ctrl_reg <= wdata_in & CTRL_WRITE_MASK;
            end
            if (addr_in == OUT_LEVEL_OFFSET) begin
                out_level_reg <= wdata_in[0];
            end
            if (addr_in == IRQ_MASK_OFFSET) begin
                irq_mask_reg <= wdata_in[IRQ_WIDTH-1:0];
            end
        end
    end

    // Three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sync_reg <= 3'h0;
            stable_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_in};
            if (sync_reg[1] == sync_reg[2]) begin
                stable_reg <= sync_reg[2];
            end
        end
    end

    // Long filter for codes 0, 4, 14 and 15
    always_comb begin
        long_filter = (fn == FN_IN_LONG) || (fn == FN_IN_SLEEPWAKE_LONG) ||
                      (fn == FN_IN_HWCTL1_LONG) || (fn == FN_IN_HWCTL2_LONG); // R10 R11 R14
        deb_limit = long_filter ? CW'(DEB_LONG) : CW'(DEB_NORMAL);
    end

    // De-bounce: the level must hold for the whole filter time before it is taken
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            deb_cnt_reg <= '0;
            deb_reg <= 1'b0;
        end else if (stable_reg == deb_reg) begin
            deb_cnt_reg <= '0;
        end else if (deb_cnt_reg >= deb_limit - CW'(1)) begin
            deb_cnt_reg <= '0;
            deb_reg <= stable_reg;
        end else begin
            deb_cnt_reg <= deb_cnt_reg + CW'(1);
        end
    end

    // Polarity applied on the way in
    assign logic_level = ctrl_reg[POL_BIT] ? deb_reg : ~deb_reg; // R06 R07

    // Edges are seen on the raw filtered pin so polarity picks the edge
    assign deb_rise = deb_reg & ~deb_prev_reg;
    assign deb_fall = ~deb_reg & deb_prev_reg;

    always_comb begin
        if (ctrl_reg[EDGE_MODE_BIT]) begin
            edge_event = deb_rise | deb_fall; // R04
        end else if (ctrl_reg[POL_BIT]) begin
            edge_event = deb_rise; // R03
        end else begin
            edge_event = deb_fall; // R03
        end
    end

    // Sticky status; a new edge wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            deb_prev_reg <= 1'b0;
            irq_status_reg <= '0;
        end else begin
            deb_prev_reg <= deb_reg;
            for (int i = 0; i < IRQ_WIDTH; i++) begin
                if (i == IRQ_EDGE_BIT && edge_event && pin_dir_in && ctrl_reg[ENABLE_BIT]) begin
                    irq_status_reg[i] <= 1'b1;
                end else if (write_in && addr_in == IRQ_STATUS_OFFSET && wdata_in[i]) begin
                    irq_status_reg[i] <= 1'b0;
                end
            end
        end
    end

    assign irq_out = |(irq_status_reg & irq_mask_reg);

    // Input function decode; all sixteen codes are defined, so no default
    // Long variants differ only in filter time, which is chosen above
    always_comb begin
        sel_level = 1'b0;
        sel_onoff = 1'b0;
        sel_sleepwake = 1'b0;
        sel_sleep = 1'b0;
        sel_poweron = 1'b0;
        sel_wdog = 1'b0;
        sel_vsa = 1'b0;
        sel_vsb = 1'b0;
        sel_hwen1 = 1'b0;
        sel_hwen2 = 1'b0;
        sel_hwctl1 = 1'b0;
        sel_hwctl2 = 1'b0;
        unique case (fn)
            FN_IN_LONG: sel_level = 1'b1; // R10
            FN_IN_NORMAL: sel_level = 1'b1; // R10
            FN_IN_ONOFF: sel_onoff = 1'b1; // R11
            FN_IN_SLEEPWAKE: sel_sleepwake = 1'b1; // R11
            FN_IN_SLEEPWAKE_LONG: sel_sleepwake = 1'b1; // R11
            FN_IN_SLEEP: sel_sleep = 1'b1; // R12
            FN_IN_POWERON: sel_poweron = 1'b1; // R12
            FN_IN_WDOG: sel_wdog = 1'b1; // R12
            FN_IN_VSA: sel_vsa = 1'b1; // R13
            FN_IN_VSB: sel_vsb = 1'b1; // R13
            FN_IN_HWEN1: sel_hwen1 = 1'b1; // R13
            FN_IN_HWEN2: sel_hwen2 = 1'b1; // R13
            FN_IN_HWCTL1: sel_hwctl1 = 1'b1; // R14
            FN_IN_HWCTL2: sel_hwctl2 = 1'b1; // R14
            FN_IN_HWCTL1_LONG: sel_hwctl1 = 1'b1; // R14
            FN_IN_HWCTL2_LONG: sel_hwctl2 = 1'b1; // R14
        endcase
    end

    // Requests only pass while the pin is an enabled input
    assign fn_active = logic_level & pin_dir_in & ctrl_reg[ENABLE_BIT];

    // Input function routing, registered outputs
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            level_out <= 1'b0;
            onoff_req_out <= 1'b0;
            sleepwake_req_out <= 1'b0;
            sleep_req_out <= 1'b0;
            poweron_req_out <= 1'b0;
            wdog_reset_out <= 1'b0;
            voltage_scale_select_a_out <= 1'b0;
            voltage_scale_select_b_out <= 1'b0;
            hw_enable1_out <= 1'b0;
            hw_enable2_out <= 1'b0;
            hw_control1_out <= 1'b0;
            hw_control2_out <= 1'b0;
        end else begin
            level_out <= fn_active & sel_level; // R10
            onoff_req_out <= fn_active & sel_onoff; // R11
            sleepwake_req_out <= fn_active & sel_sleepwake; // R11
            sleep_req_out <= fn_active & sel_sleep; // R12
            poweron_req_out <= fn_active & sel_poweron; // R12
            wdog_reset_out <= fn_active & sel_wdog; // R12
            voltage_scale_select_a_out <= fn_active & sel_vsa; // R13
            voltage_scale_select_b_out <= fn_active & sel_vsb; // R13
            hw_enable1_out <= fn_active & sel_hwen1; // R13
            hw_enable2_out <= fn_active & sel_hwen2; // R13
            hw_control1_out <= fn_active & sel_hwctl1; // R14
            hw_control2_out <= fn_active & sel_hwctl2; // R14
        end
    end

    // Output source selection; reserved codes drive the inactive level
    always_comb begin
        unique case (fn)
            FN_OUT_LEVEL: src_level = out_level_reg; // R15
            FN_OUT_OSC: src_level = osc_32k_in; // R15
            FN_OUT_ON: src_level = on_state_in; // R15
            FN_OUT_SLEEP: src_level = sleep_state_in; // R15
            FN_OUT_PSC: src_level = state_change_in; // R16
            FN_OUT_VSA_DONE: src_level = vsa_done_in; // R17
            FN_OUT_VSB_DONE: src_level = vsb_done_in; // R17
            FN_OUT_EXTEN1: src_level = ext_enable1_in; // R17
            FN_OUT_EXTEN2: src_level = ext_enable2_in; // R17
            FN_OUT_SYSTEM_SUPPLY_GOOD: src_level = system_supply_good_in; // R18
            FN_OUT_PGOOD: src_level = converter_power_good_in; // R18
            FN_OUT_PWRCLK: src_level = power_clk_2m_in; // R19
            FN_OUT_AUXRST: src_level = aux_reset_in; // R19
            default: src_level = 1'b0; // R16
        endcase
        drive_level = ctrl_reg[POL_BIT] ? src_level : ~src_level; // R06 R07
    end

    // Pin driver registered so the pad sees no decode glitches
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pin_out <= 1'b0;
            pin_oe_out <= 1'b0;
        end else if (!ctrl_reg[ENABLE_BIT] || pin_dir_in) begin
            pin_out <= 1'b0; // R01 R09
            pin_oe_out <= 1'b0;
        end else if (ctrl_reg[OD_BIT]) begin
            pin_out <= 1'b0; // R08
            pin_oe_out <= ~drive_level;
        end else begin
            pin_out <= drive_level;
            pin_oe_out <= 1'b1;
        end
    end

    // Pad controls; pulls are released while tri-stated by the enable
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pull_up_out <= 1'b0;
            pull_down_out <= 1'b0;
            supply_select_out <= 1'b0;
        end else begin
            pull_up_out <= ctrl_reg[ENABLE_BIT] && pull_sel == PULL_UP; // R02
            pull_down_out <= ctrl_reg[ENABLE_BIT] && pull_sel == PULL_DOWN; // R02
            supply_select_out <= ctrl_reg[SUPPLY_BIT]; // R05
        end
    end

    // Read port: data valid the cycle after the strobe, unmapped reads zero
    always_comb begin
        rdata_next = 16'h0000;
        unique case (addr_in)
            CTRL_OFFSET: rdata_next = ctrl_reg;
            OUT_LEVEL_OFFSET: rdata_next = {15'h0000, out_level_reg};
            IRQ_STATUS_OFFSET: rdata_next = {{(16-IRQ_WIDTH){1'b0}}, irq_status_reg};
            IRQ_MASK_OFFSET: rdata_next = {{(16-IRQ_WIDTH){1'b0}}, irq_mask_reg};
            PIN_STATE_OFFSET: rdata_next = {14'h0000, logic_level, deb_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rdata_out <= 16'h0000;
        end else if (read_in) begin
            rdata_out <= rdata_next;
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule : pin7_control

// File: verilog/pin7_pkg.sv
// Package with register map, field layout and timing constants for the pin 7 control block
package pin7_pkg;
    localparam logic [15:0] CTRL_OFFSET = 16'h403e;
    localparam logic [15:0] OUT_LEVEL_OFFSET = 16'h4100;
    localparam logic [15:0] IRQ_STATUS_OFFSET = 16'h4101;
    localparam logic [15:0] IRQ_MASK_OFFSET = 16'h4102;
    localparam logic [15:0] PIN_STATE_OFFSET = 16'h4103;
    localparam int DIR_BIT = 15;
    localparam int PULL_HI = 14;
    localparam int PULL_LO = 13;
    localparam int EDGE_MODE_BIT = 12;
    localparam int SUPPLY_BIT = 11;
    localparam int POL_BIT = 10;
    localparam int OD_BIT = 9;
    localparam int ENABLE_BIT = 7;
    localparam int FN_HI = 3;
    localparam int FN_LO = 0;
    // Bits 8 and 6:4 are reserved and read as zero
    localparam logic [15:0] CTRL_WRITE_MASK = 16'hfe8f;
    localparam logic [15:0] CTRL_RESET = 16'ha400;
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam int IRQ_EDGE_BIT = 0;
    localparam int IRQ_WIDTH = 1;
    // Function codes, input direction
    localparam logic [3:0] FN_IN_LONG = 4'h0;
    localparam logic [3:0] FN_IN_NORMAL = 4'h1;
    localparam logic [3:0] FN_IN_ONOFF = 4'h2;
    localparam logic [3:0] FN_IN_SLEEPWAKE = 4'h3;
    localparam logic [3:0] FN_IN_SLEEPWAKE_LONG = 4'h4;
    localparam logic [3:0] FN_IN_SLEEP = 4'h5;
    localparam logic [3:0] FN_IN_POWERON = 4'h6;
    localparam logic [3:0] FN_IN_WDOG = 4'h7;
    localparam logic [3:0] FN_IN_VSA = 4'h8;
    localparam logic [3:0] FN_IN_VSB = 4'h9;
    localparam logic [3:0] FN_IN_HWEN1 = 4'ha;
    localparam logic [3:0] FN_IN_HWEN2 = 4'hb;
    localparam logic [3:0] FN_IN_HWCTL1 = 4'hc;
    localparam logic [3:0] FN_IN_HWCTL2 = 4'hd;
    localparam logic [3:0] FN_IN_HWCTL1_LONG = 4'he;
    localparam logic [3:0] FN_IN_HWCTL2_LONG = 4'hf;
    // Function codes, output direction
    localparam logic [3:0] FN_OUT_LEVEL = 4'h0;
    localparam logic [3:0] FN_OUT_OSC = 4'h1;
    localparam logic [3:0] FN_OUT_ON = 4'h2;
    localparam logic [3:0] FN_OUT_SLEEP = 4'h3;
    localparam logic [3:0] FN_OUT_PSC = 4'h4;
    localparam logic [3:0] FN_OUT_VSA_DONE = 4'h8;
    localparam logic [3:0] FN_OUT_VSB_DONE = 4'h9;
    localparam logic [3:0] FN_OUT_EXTEN1 = 4'ha;
    localparam logic [3:0] FN_OUT_EXTEN2 = 4'hb;
    localparam logic [3:0] FN_OUT_SYSTEM_SUPPLY_GOOD = 4'hc;
    localparam logic [3:0] FN_OUT_PGOOD = 4'hd;
    localparam logic [3:0] FN_OUT_PWRCLK = 4'he;
    localparam logic [3:0] FN_OUT_AUXRST = 4'hf;
    // De-bounce times
    localparam int CLK_MHZ = 200;
    localparam int DEB_NORMAL_US = 1;
    localparam int DEB_LONG_US = 100;
    localparam int DEB_NORMAL_CYCLES = DEB_NORMAL_US * CLK_MHZ;
    localparam int DEB_LONG_CYCLES = DEB_LONG_US * CLK_MHZ;
endpackage : pin7_pkg
